/* File: pin_sync3.sv */
// Three-stage synchroniser for a pin level; the level moves once stages two and three agree.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  output logic      level_out
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      level_out <= RESET_LEVEL;
    end else if (s2_q == s3_q) begin
      level_out <= s3_q;
    end
  end

endmodule

/* File: usb_clk_far_side.sv */
// Model of the resonator, loop filter and USB bus idle level.
`timescale 1ns/1ps
module usb_clk_far_side #(
  parameter int RES_MHZ     = 12,
  parameter int LOCK_CYCLES = 16
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       pll_run_in,
  input  wire logic [4:0] ref_mhz_in,
  input  wire logic       idle_req_in,
  output logic            bus_idle_out,
  output logic            locked_out
);
  logic [7:0] lock_q;
  // The loop only settles when the reference matches the fitted resonator.
  always_ff @(posedge clk_in) begin
    if (rst_in || !pll_run_in || ref_mhz_in != 5'(RES_MHZ)) begin
      lock_q <= 8'h00;
    end else if (lock_q != 8'(LOCK_CYCLES)) begin
      lock_q <= lock_q + 8'h01;
    end
  end
  assign locked_out = (lock_q == 8'(LOCK_CYCLES));
  assign bus_idle_out = idle_req_in;
endmodule

/* File: usb_clkctl_pkg.sv */
// Types shared by the USB clock control design.
package usb_clkctl_pkg;

  typedef enum logic [2:0] {
    DIV_STOPPED = 3'h0,
    DIV_4M8     = 3'h1,
    DIV_6M      = 3'h2,
    DIV_8M      = 3'h3,
    DIV_12M     = 3'h4,
    DIV_24M     = 3'h5,
    DIV_4M      = 3'h6,
    DIV_16M     = 3'h7
  } div_freq_t;

  typedef enum logic [2:0] {
    REF_8M  = 3'h0,
    REF_9M  = 3'h1,
    REF_10M = 3'h2,
    REF_11M = 3'h3,
    REF_12M = 3'h4,
    REF_2M  = 3'h5,
    REF_3M  = 3'h6,
    REF_16M = 3'h7
  } pll_ref_t;

endpackage

/* File: usb_clkctl_regs.svh */
// Register indices, field positions, reset values and timing counts of the USB clock control.
//
// How it works
// - divided clock select code sets output frequency
// - main select flag picks divided clock source
// - divided main clock becomes system clock only with system select flag set
// - pin carries divided clock when enabled
// - reference select states attached resonator frequency
// - PLL runs only with both stops clear
// - operation register holds USB clock gates
// - gate bits choose full, reset or activity
// - suspend flag after 3 ms idle, sticky
// - interrupt while suspend flag and enable set
`ifndef USB_CLKCTL_REGS_SVH
`define USB_CLKCTL_REGS_SVH

// Register indices; byte address is four times the index.
`define IDX_DIVCLK_CTRL      16'hfe04
`define IDX_PLL_CTRL         16'hfe0d
`define IDX_USB_OP_CTRL      16'hfe80
`define IDX_PIN_SYS_CTRL     16'hfe10

// Divided clock control fields.
`define DIV_MAIN_SEL_BIT     6
`define DIV_PIN_OE_BIT       5
`define DIV_FREQ_MSB         2
`define DIV_FREQ_LSB         0

// PLL control fields.
`define PLL_REF_MSB          7
`define PLL_REF_LSB          5
`define PLL_VCO_STOP_BIT     3
`define PLL_CMP_STOP_BIT     2

// USB operation control fields.
`define OP_GATE_UPPER_BIT    7
`define OP_GATE_LOWER_BIT    6
`define OP_PULLUP_A_BIT      5
`define OP_SUSP_FLAG_BIT     3
`define OP_SUSP_IRQ_EN_BIT   2
`define OP_DP_IN_DIS_BIT     1
`define OP_DM_IN_DIS_BIT     0

// Pin and system clock control fields.
`define PS_PIN_OE_BIT        7
`define PS_PULLUP_B_BIT      6
`define PS_PIN_LATCH_BIT     3
`define PS_SYS_MAIN_SEL_BIT  0

// Reset values.
`define RST_DIVCLK_CTRL      8'h00
`define RST_PLL_CTRL         8'h00
`define RST_USB_OP_CTRL      8'h00
`define RST_PIN_SYS_CTRL     8'h00

// Divider phase accumulator: increment is twice the frequency in 0.1 MHz units,
// modulus is the 40 MHz clock in the same units, so each wrap is one half period.
`define NCO_MODULUS          10'h190
`define NCO_INC_4M8          10'h060
`define NCO_INC_6M           10'h078
`define NCO_INC_8M           10'h0a0
`define NCO_INC_12M          10'h0f0
`define NCO_INC_24M          10'h1e0
`define NCO_INC_4M           10'h050
`define NCO_INC_16M          10'h140

// Suspend timing.
`define CLK_FREQ_MHZ         40
`define SUSPEND_IDLE_US      3000
`define SUSPEND_IDLE_CYCLES  (`SUSPEND_IDLE_US * `CLK_FREQ_MHZ)

`endif

/* File: usb_clkctl_sva.sv */
// Concurrent checks on the USB clock control ports.
`timescale 1ns/1ps
module usb_clkctl_sva #(
  parameter int unsigned SUSPEND_IDLE_CYCLES = 20
) (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        BUS_IDLE_IN,
  input wire logic        MAIN_CLOCK_IS_DIVIDED_OUT,
  input wire logic        SYSTEM_CLOCK_IS_DIVIDED_OUT,
  input wire logic        DIVIDED_CLOCK_OUT,
  input wire logic        PLL_RUN_OUT,
  input wire logic        USB_BLOCK_ENABLE_OUT,
  input wire logic        USB_RESET_DETECT_ENABLE_OUT,
  input wire logic        USB_ACTIVE_DETECT_ENABLE_OUT,
  input wire logic        SUSPEND_IRQ_OUT
);
  // Consecutive idle cycles, saturating at 100000, below the default suspend count of 120000.
  int unsigned idle_q;
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !BUS_IDLE_IN) begin
      idle_q <= 0;
    end else if (idle_q < 100000) begin
      idle_q <= idle_q + 1;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready; PSEL_IN && !PENABLE_IN |=> PREADY_OUT; endproperty
  a_ready: assert property (p_ready) else $error("ready late");
  property p_one; PREADY_OUT |-> PSEL_IN && PENABLE_IN && PRDATA_OUT[31:8] == 24'h0; endproperty
  a_one: assert property (p_one) else $error("ready outside access");
  property p_err; PSLVERR_OUT |-> PREADY_OUT && PRDATA_OUT == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error response");
  property p_sys; SYSTEM_CLOCK_IS_DIVIDED_OUT |-> MAIN_CLOCK_IS_DIVIDED_OUT; endproperty
  a_sys: assert property (p_sys) else $error("system clock source");
  property p_run; !PLL_RUN_OUT && !$past(PLL_RUN_OUT) |-> !DIVIDED_CLOCK_OUT; endproperty
  a_run: assert property (p_run) else $error("divided clock without pll");
  property p_rise; $rose(DIVIDED_CLOCK_OUT) |-> $past(PLL_RUN_OUT); endproperty
  a_rise: assert property (p_rise) else $error("divided clock edge");
  property p_gate; USB_BLOCK_ENABLE_OUT |-> USB_RESET_DETECT_ENABLE_OUT; endproperty
  a_gate: assert property (p_gate) else $error("gate decode");
  property p_act; !$past(RST_IN) |-> USB_ACTIVE_DETECT_ENABLE_OUT; endproperty
  a_act: assert property (p_act) else $error("activity detect off");
  property p_irq;
    $rose(SUSPEND_IRQ_OUT) && !$past(PREADY_OUT) && !$past(PREADY_OUT, 2)
      && !$past(PREADY_OUT, 3) |-> idle_q >= SUSPEND_IDLE_CYCLES;
  endproperty
  a_irq: assert property (p_irq) else $error("suspend too early");
  c_irq: cover property ($rose(SUSPEND_IRQ_OUT));
  c_err: cover property (PSLVERR_OUT);
  c_dclk: cover property ($rose(DIVIDED_CLOCK_OUT));
  c_blk: cover property (USB_BLOCK_ENABLE_OUT);
endmodule
bind usb_clock_generation_control usb_clkctl_sva #(
  .SUSPEND_IDLE_CYCLES(SUSPEND_IDLE_CYCLES)
) chk_sva (
  .CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .BUS_IDLE_IN(BUS_IDLE_IN), .MAIN_CLOCK_IS_DIVIDED_OUT(MAIN_CLOCK_IS_DIVIDED_OUT),
  .SYSTEM_CLOCK_IS_DIVIDED_OUT(SYSTEM_CLOCK_IS_DIVIDED_OUT),
  .DIVIDED_CLOCK_OUT(DIVIDED_CLOCK_OUT), .PLL_RUN_OUT(PLL_RUN_OUT),
  .USB_BLOCK_ENABLE_OUT(USB_BLOCK_ENABLE_OUT),
  .USB_RESET_DETECT_ENABLE_OUT(USB_RESET_DETECT_ENABLE_OUT),
  .USB_ACTIVE_DETECT_ENABLE_OUT(USB_ACTIVE_DETECT_ENABLE_OUT),
  .SUSPEND_IRQ_OUT(SUSPEND_IRQ_OUT)
);

/* File: usb_clock_generation_control.sv */
// USB clock generation and control block with an APB register slave.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`include "usb_clkctl_regs.svh"
module usb_clock_generation_control #(
  parameter int unsigned SUSPEND_IDLE_CYCLES = `SUSPEND_IDLE_CYCLES
) (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [17:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        BUS_IDLE_IN,
  output logic             CLOCK_OUTPUT_PIN_OUT,
  output logic             CLOCK_OUTPUT_PIN_OE_OUT,
  output logic             MAIN_CLOCK_IS_DIVIDED_OUT,
  output logic             SYSTEM_CLOCK_IS_DIVIDED_OUT,
  output logic             DIVIDED_CLOCK_OUT,
  output logic [2:0]       PLL_REFERENCE_SELECT_OUT,
  output logic [4:0]       PLL_REFERENCE_MHZ_OUT,
  output logic             PLL_RUN_OUT,
  output logic             USB_BLOCK_ENABLE_OUT,
  output logic             USB_RESET_DETECT_ENABLE_OUT,
  output logic             USB_ACTIVE_DETECT_ENABLE_OUT,
  output logic             PULLUP_PIN_A_OUT,
  output logic             PULLUP_PIN_B_OUT,
  output logic             DPLUS_INPUT_DISABLE_OUT,
  output logic             DMINUS_INPUT_DISABLE_OUT,
  output logic             SUSPEND_IRQ_OUT
);

  initial begin
    if (SUSPEND_IDLE_CYCLES < 2 || SUSPEND_IDLE_CYCLES > 32'h00ffffff) begin
      $error("SUSPEND_IDLE_CYCLES out of range");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one access cycle, read data registered at the setup cycle.

  localparam logic [17:0] ADDR_DIV = {`IDX_DIVCLK_CTRL, 2'b00};
  localparam logic [17:0] ADDR_PLL = {`IDX_PLL_CTRL, 2'b00};
  localparam logic [17:0] ADDR_OP  = {`IDX_USB_OP_CTRL, 2'b00};
  localparam logic [17:0] ADDR_PS  = {`IDX_PIN_SYS_CTRL, 2'b00};

  logic [7:0]  div_ctrl_q;
  logic [7:0]  pll_ctrl_q;
  logic [7:0]  op_ctrl_q;
  logic [7:0]  ps_ctrl_q;
  logic        susp_flag_q;
  logic        setup;
  logic        wr_en;
  logic        hit;
  logic [7:0]  rd_byte;

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign wr_en = PSEL_IN & PENABLE_IN & PREADY_OUT & PWRITE_IN & ~PSLVERR_OUT;

  always_comb begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (PADDR_IN)
      ADDR_DIV: rd_byte = div_ctrl_q;
      ADDR_PLL: rd_byte = pll_ctrl_q;
      ADDR_OP: begin
        rd_byte                    = op_ctrl_q;
        rd_byte[`OP_SUSP_FLAG_BIT] = susp_flag_q;
      end
      ADDR_PS:  rd_byte = ps_ctrl_q;
      default:  hit = 1'b0;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      PREADY_OUT  <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT  <= 32'h0000_0000;
    end else begin
      PREADY_OUT  <= setup;
      PSLVERR_OUT <= setup & ~hit;
      if (setup) begin
        PRDATA_OUT <= (hit && !PWRITE_IN) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers; reserved and test bits are stored as written.

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      div_ctrl_q <= `RST_DIVCLK_CTRL;
      pll_ctrl_q <= `RST_PLL_CTRL;
      op_ctrl_q  <= `RST_USB_OP_CTRL;
      ps_ctrl_q  <= `RST_PIN_SYS_CTRL;
    end else if (wr_en) begin
      case (PADDR_IN)
        ADDR_DIV: div_ctrl_q <= PWDATA_IN[7:0];
        ADDR_PLL: pll_ctrl_q <= PWDATA_IN[7:0];
        ADDR_OP:  op_ctrl_q  <= PWDATA_IN[7:0];
        ADDR_PS:  ps_ctrl_q  <= PWDATA_IN[7:0];
        default:  ps_ctrl_q  <= ps_ctrl_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Suspend detection: idle must last the full time; the flag is sticky.

  logic        bus_idle;
  logic [23:0] idle_cnt_q;
  logic        idle_done;
  logic        susp_clear;

  pin_sync3 #(
    .RESET_LEVEL (1'b0)
  ) u_idle_sync (
    .clk_in    (CLK_IN),
    .rst_in    (RST_IN),
    .pin_in    (BUS_IDLE_IN),
    .level_out (bus_idle)
  );

  assign idle_done  = (idle_cnt_q == 24'(SUSPEND_IDLE_CYCLES - 1));
  assign susp_clear = wr_en && (PADDR_IN == ADDR_OP) && !PWDATA_IN[`OP_SUSP_FLAG_BIT];

  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !bus_idle) begin
      idle_cnt_q <= 24'h00_0000;
    end else if (!idle_done) begin
      idle_cnt_q <= idle_cnt_q + 24'h00_0001;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      susp_flag_q <= 1'b0;
    end else if (bus_idle && idle_done) begin
      susp_flag_q <= 1'b1;
    end else if (susp_clear) begin
      susp_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      SUSPEND_IRQ_OUT <= 1'b0;
    end else begin
      SUSPEND_IRQ_OUT <= susp_flag_q & op_ctrl_q[`OP_SUSP_IRQ_EN_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // PLL control and divided clock generator.

  logic       pll_run;
  logic [2:0] freq_code;
  logic [9:0] inc_sel;
  logic [9:0] inc_q;
  logic [9:0] acc_q;
  logic [10:0] acc_sum;
  logic       wrap;
  logic       divclk_q;
  logic [4:0] ref_mhz;

  assign pll_run   = !pll_ctrl_q[`PLL_VCO_STOP_BIT] && !pll_ctrl_q[`PLL_CMP_STOP_BIT];
  assign freq_code = div_ctrl_q[`DIV_FREQ_MSB:`DIV_FREQ_LSB];

  always_comb begin
    case (usb_clkctl_pkg::div_freq_t'(freq_code))
      usb_clkctl_pkg::DIV_4M8: inc_sel = `NCO_INC_4M8;
      usb_clkctl_pkg::DIV_6M:  inc_sel = `NCO_INC_6M;
      usb_clkctl_pkg::DIV_8M:  inc_sel = `NCO_INC_8M;
      usb_clkctl_pkg::DIV_12M: inc_sel = `NCO_INC_12M;
      usb_clkctl_pkg::DIV_24M: inc_sel = `NCO_INC_24M;
      usb_clkctl_pkg::DIV_4M:  inc_sel = `NCO_INC_4M;
      usb_clkctl_pkg::DIV_16M: inc_sel = `NCO_INC_16M;
      default:                 inc_sel = 10'h000;
    endcase
  end

  assign acc_sum = {1'b0, acc_q} + {1'b0, inc_q};
  assign wrap    = (acc_sum >= {1'b0, `NCO_MODULUS});

  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !pll_run || inc_sel == 10'h000) begin
      inc_q    <= 10'h000;
      acc_q    <= 10'h000;
      divclk_q <= 1'b0;
    end else begin
      if (!divclk_q && (wrap || inc_q == 10'h000)) begin
        inc_q <= inc_sel;
      end
      if (inc_q == 10'h000) begin
        acc_q <= 10'h000;
      end else if (wrap) begin
        acc_q    <= 10'(acc_sum - {1'b0, `NCO_MODULUS});
        divclk_q <= ~divclk_q;
      end else begin
        acc_q <= acc_sum[9:0];
      end
    end
  end

  always_comb begin
    case (usb_clkctl_pkg::pll_ref_t'(pll_ctrl_q[`PLL_REF_MSB:`PLL_REF_LSB]))
      usb_clkctl_pkg::REF_8M:  ref_mhz = 5'h08;
      usb_clkctl_pkg::REF_9M:  ref_mhz = 5'h09;
      usb_clkctl_pkg::REF_10M: ref_mhz = 5'h0a;
      usb_clkctl_pkg::REF_11M: ref_mhz = 5'h0b;
      usb_clkctl_pkg::REF_12M: ref_mhz = 5'h0c;
      usb_clkctl_pkg::REF_2M:  ref_mhz = 5'h02;
      usb_clkctl_pkg::REF_3M:  ref_mhz = 5'h03;
      default:                 ref_mhz = 5'h10;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered control outputs.

  logic pin_divclk_en;
  assign pin_divclk_en = div_ctrl_q[`DIV_PIN_OE_BIT] && ps_ctrl_q[`PS_PIN_OE_BIT] &&
                         !ps_ctrl_q[`PS_PIN_LATCH_BIT];

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      CLOCK_OUTPUT_PIN_OUT         <= 1'b0;
      CLOCK_OUTPUT_PIN_OE_OUT      <= 1'b0;
      MAIN_CLOCK_IS_DIVIDED_OUT    <= 1'b0;
      SYSTEM_CLOCK_IS_DIVIDED_OUT  <= 1'b0;
      DIVIDED_CLOCK_OUT            <= 1'b0;
      PLL_REFERENCE_SELECT_OUT     <= 3'h0;
      PLL_REFERENCE_MHZ_OUT        <= 5'h00;
      PLL_RUN_OUT                  <= 1'b0;
      USB_BLOCK_ENABLE_OUT         <= 1'b0;
      USB_RESET_DETECT_ENABLE_OUT  <= 1'b0;
      USB_ACTIVE_DETECT_ENABLE_OUT <= 1'b0;
      PULLUP_PIN_A_OUT             <= 1'b0;
      PULLUP_PIN_B_OUT             <= 1'b0;
      DPLUS_INPUT_DISABLE_OUT      <= 1'b0;
      DMINUS_INPUT_DISABLE_OUT     <= 1'b0;
    end else begin
      CLOCK_OUTPUT_PIN_OE_OUT      <= ps_ctrl_q[`PS_PIN_OE_BIT];
      CLOCK_OUTPUT_PIN_OUT         <= pin_divclk_en ? divclk_q :
                                      ps_ctrl_q[`PS_PIN_LATCH_BIT];
      MAIN_CLOCK_IS_DIVIDED_OUT    <= div_ctrl_q[`DIV_MAIN_SEL_BIT];
      SYSTEM_CLOCK_IS_DIVIDED_OUT  <= div_ctrl_q[`DIV_MAIN_SEL_BIT] &&
                                      ps_ctrl_q[`PS_SYS_MAIN_SEL_BIT];
      DIVIDED_CLOCK_OUT            <= divclk_q;
      PLL_REFERENCE_SELECT_OUT     <= pll_ctrl_q[`PLL_REF_MSB:`PLL_REF_LSB];
      PLL_REFERENCE_MHZ_OUT        <= ref_mhz;
      PLL_RUN_OUT                  <= pll_run;
      USB_BLOCK_ENABLE_OUT         <= op_ctrl_q[`OP_GATE_UPPER_BIT] &&
                                      op_ctrl_q[`OP_GATE_LOWER_BIT];
      USB_RESET_DETECT_ENABLE_OUT  <= op_ctrl_q[`OP_GATE_UPPER_BIT];
      USB_ACTIVE_DETECT_ENABLE_OUT <= 1'b1;
      PULLUP_PIN_A_OUT             <= op_ctrl_q[`OP_PULLUP_A_BIT];
      PULLUP_PIN_B_OUT             <= ps_ctrl_q[`PS_PULLUP_B_BIT];
      DPLUS_INPUT_DISABLE_OUT      <= op_ctrl_q[`OP_DP_IN_DIS_BIT];
      DMINUS_INPUT_DISABLE_OUT     <= op_ctrl_q[`OP_DM_IN_DIS_BIT];
    end
  end

endmodule

/* File: usb_clock_generation_control_test.sv */
// Self-checking testbench for the USB clock control block.
`timescale 1ns/1ps
`include "usb_clkctl_regs.svh"
module usb_clock_generation_control_test;
  logic        clk, rst, psel, pen, pwr, idle_req, e;
  logic [17:0] padr;
  logic [31:0] pwd, prd;
  logic [7:0]  v;
  logic        prdy, perr, pin, pin_oe, main_div, sys_div, dclk, run, blk, rdet, adet;
  logic        pua, pub, dpd, dmd, irq, bus_idle, locked;
  logic [2:0]  rsel;
  logic [4:0]  rmhz;
  int          fail_count, n_tests, cyc;
  usb_clock_generation_control #(.SUSPEND_IDLE_CYCLES(20)) dut (
    .CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(padr), .PWDATA_IN(pwd), .PRDATA_OUT(prd), .PREADY_OUT(prdy),
    .PSLVERR_OUT(perr), .BUS_IDLE_IN(bus_idle), .CLOCK_OUTPUT_PIN_OUT(pin),
    .CLOCK_OUTPUT_PIN_OE_OUT(pin_oe), .MAIN_CLOCK_IS_DIVIDED_OUT(main_div),
    .SYSTEM_CLOCK_IS_DIVIDED_OUT(sys_div), .DIVIDED_CLOCK_OUT(dclk),
    .PLL_REFERENCE_SELECT_OUT(rsel), .PLL_REFERENCE_MHZ_OUT(rmhz), .PLL_RUN_OUT(run),
    .USB_BLOCK_ENABLE_OUT(blk), .USB_RESET_DETECT_ENABLE_OUT(rdet),
    .USB_ACTIVE_DETECT_ENABLE_OUT(adet), .PULLUP_PIN_A_OUT(pua), .PULLUP_PIN_B_OUT(pub),
    .DPLUS_INPUT_DISABLE_OUT(dpd), .DMINUS_INPUT_DISABLE_OUT(dmd), .SUSPEND_IRQ_OUT(irq)
  );
  usb_clk_far_side #(.RES_MHZ(12), .LOCK_CYCLES(16)) far (
    .clk_in(clk), .rst_in(rst), .pll_run_in(run), .ref_mhz_in(rmhz),
    .idle_req_in(idle_req), .bus_idle_out(bus_idle), .locked_out(locked)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  // Leaves select high so that a further setup may follow at once.
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    v = prd[7:0];
    e = perr;
  endtask
  task automatic rel;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    rel;
    repeat (3) @(posedge clk);
  endtask
  task automatic chkrd(input string nm, input logic [15:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    rel;
    @(posedge clk);
    chk(nm, 32'(v), 32'(x));
  endtask
  // Counts rising edges of the divided clock or the pin over 400 cycles.
  task automatic rate(input string nm, input logic sel, input int x);
    int n;
    logic p;
    n = 0;
    repeat (40) @(posedge clk);
    p = sel ? pin : dclk;
    repeat (400) begin
      @(posedge clk);
      if ((sel ? pin : dclk) && !p) n++;
      p = sel ? pin : dclk;
    end
    chk(nm, 32'(n >= x - 1 && n <= x + 1), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chkrd("div reset", `IDX_DIVCLK_CTRL, 8'h00);
    chkrd("pll reset", `IDX_PLL_CTRL, 8'h00);
    chkrd("op reset", `IDX_USB_OP_CTRL, 8'h00);
    chk("reset outputs", 32'({run, adet, blk, dclk}), 32'hc);
    apb(1'b1, `IDX_DIVCLK_CTRL, 8'h60);
    apb(1'b1, `IDX_PLL_CTRL, 8'he3);
    apb(1'b1, `IDX_USB_OP_CTRL, 8'h27);
    apb(1'b1, `IDX_PIN_SYS_CTRL, 8'h40);
    apb(1'b0, 16'hfe05, 8'h00);
    chk("unmapped", 32'({e, v}), 32'h100);
    rel;
    repeat (3) @(posedge clk);
    chkrd("div rw", `IDX_DIVCLK_CTRL, 8'h60);
    chkrd("pll rw", `IDX_PLL_CTRL, 8'he3);
    chkrd("op rw", `IDX_USB_OP_CTRL, 8'h27);
    chk("pullups", 32'({pua, pub, dpd, dmd}), 32'hf);
    wr(`IDX_PLL_CTRL, 8'h00);
    wr(`IDX_USB_OP_CTRL, 8'h00);
    wr(`IDX_PIN_SYS_CTRL, 8'h00);
    wr(`IDX_DIVCLK_CTRL, 8'h00);
    $display("registers done");
  endtask
  task automatic t_div;
    // The 24 MHz code lies above half the 40 MHz clock, so the output toggles every edge.
    int x[8] = '{0, 48, 60, 80, 120, 200, 40, 160};
    for (int k = 1; k < 8; k++) begin
      wr(`IDX_DIVCLK_CTRL, 8'h00);
      rate("div stop", 1'b0, 0);
      wr(`IDX_DIVCLK_CTRL, 8'(k));
      rate("div rate", 1'b0, x[k]);
    end
    wr(`IDX_PLL_CTRL, 8'h0c);
    rate("pll stop", 1'b0, 0);
    wr(`IDX_PLL_CTRL, 8'h00);
    wr(`IDX_DIVCLK_CTRL, 8'h00);
    $display("divider done");
  endtask
  task automatic t_clk;
    wr(`IDX_DIVCLK_CTRL, 8'h04);
    wr(`IDX_PIN_SYS_CTRL, 8'h80);
    chk("pin oe", 32'(pin_oe), 32'h1);
    rate("pin no flag", 1'b1, 0);
    wr(`IDX_DIVCLK_CTRL, 8'h64);
    chk("main", 32'({main_div, sys_div}), 32'h2);
    rate("pin out", 1'b1, 120);
    wr(`IDX_PIN_SYS_CTRL, 8'h81);
    chk("system", 32'({main_div, sys_div}), 32'h3);
    wr(`IDX_PIN_SYS_CTRL, 8'h89);
    rate("pin latch", 1'b1, 0);
    chk("pin level", 32'(pin), 32'h1);
    wr(`IDX_PIN_SYS_CTRL, 8'h00);
    wr(`IDX_DIVCLK_CTRL, 8'h04);
    chk("main off", 32'({main_div, sys_div}), 32'h0);
    wr(`IDX_DIVCLK_CTRL, 8'h00);
    $display("clock select done");
  endtask
  task automatic t_pll;
    int m[8] = '{8, 9, 10, 11, 12, 2, 3, 16};
    for (int k = 0; k < 8; k++) begin
      wr(`IDX_PLL_CTRL, {3'(k), 5'h00});
      chk("ref", 32'({rsel, rmhz}), 32'({3'(k), 5'(m[k])}));
    end
    for (int s = 0; s < 4; s++) begin
      wr(`IDX_PLL_CTRL, {4'h8, 2'(s), 2'b00});
      repeat (20) @(posedge clk);
      chk("pll run", 32'({run, locked}), 32'({s == 0, s == 0}));
    end
    wr(`IDX_PLL_CTRL, 8'h00);
    $display("pll done");
  endtask
  task automatic t_usb;
    for (int g = 0; g < 4; g++) begin
      wr(`IDX_USB_OP_CTRL, {2'(g), 6'h00});
      chk("gates", 32'({blk, rdet, adet}), 32'({g == 3, g >= 2, 1'b1}));
    end
    wr(`IDX_USB_OP_CTRL, 8'h00);
    $display("usb gates done");
  endtask
  task automatic t_susp;
    int n;
    wr(`IDX_USB_OP_CTRL, 8'h04);
    idle_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq !== 1'b1);
    chk("suspend delay", 32'(n >= 20 && n <= 35), 32'h1);
    idle_req <= 1'b0;
    repeat (10) @(posedge clk);
    chkrd("sticky", `IDX_USB_OP_CTRL, 8'h0c);
    wr(`IDX_USB_OP_CTRL, 8'h04);
    chk("irq clear", 32'(irq), 32'h0);
    wr(`IDX_USB_OP_CTRL, 8'h00);
    idle_req <= 1'b1;
    repeat (40) @(posedge clk);
    chk("irq masked", 32'(irq), 32'h0);
    idle_req <= 1'b0;
    chkrd("flag", `IDX_USB_OP_CTRL, 8'h08);
    $display("suspend done");
  endtask
  initial begin
    {psel, pen, pwr, padr, pwd, idle_req} = '0;
    {fail_count, n_tests, cyc} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_div;
    t_clk;
    t_pll;
    t_usb;
    t_susp;
    wrap_up;
  end
endmodule
